// ---- rtl/scrb_pkg.sv ----
`default_nettype none
package scrb_pkg;

  // ==========================================================================
  // Register field positions
  localparam int unsigned CFG_RES_HIGH_BIT = 7;
  localparam int unsigned CFG_SUPPLY_BIT   = 6;
  localparam int unsigned CFG_HEATER_BIT   = 2;
  localparam int unsigned CFG_RES_LOW_BIT  = 0;
  localparam int unsigned HTR_LEVEL_MSB    = 3;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] CFG_RESET       = 8'h3A;
  localparam logic [7:0] HTR_RESET       = 8'h00;
  // Reserved positions of the configuration register always read as one
  localparam logic [7:0] CFG_RESERVED_BITS_MASK   = 8'h3A;

  // ==========================================================================
  // Serial framing
  localparam logic [3:0] BYTE_BITS       = 4'h8;
  localparam logic [3:0] LAST_TX_BIT     = 4'h7;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_CMD,
    ST_CMD_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_MACK
  } scrb_state_type;

endpackage

`default_nettype wire

// ---- rtl/scrb_register_bank.sv ----
// Notes on behaviour
// R1: The host writes no register other than the two configuration registers; reads elsewhere are undefined.
// R2: Reserved bits of the configuration register read as one and ignore writes.
// R3: The host should read a register first and write its reserved bits back unchanged.
// R4: The supply-low flag is read-only; resolution and heater enable bits are read/write.
// R5: The resolution selector is bit 7 (high) and bit 0 (low) of the configuration register.
// R6: Bit 6 reads one while the supply sits in the low band, zero while it is adequate.
// R7: Bit 2 of the configuration register switches the heater on (1) or off (0).
// R8: The heater register holds a four-bit drive level in bits 3 to 0; bits 7 to 4 are reserved (the code stores them and reads them back as written).
// R9: A write is start, address+W, write command, one data byte, stop, each byte acknowledged.
// R10: A read is a read command, repeated start, address+R, one data byte, then NACK and stop.
// R11: Distinct read and write command codes select each of the two registers.
`timescale 1ns/100ps
`default_nettype none

module scrb_register_bank
  import scrb_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR   = 7'h2A,  // Arbitrary default
  parameter logic [7:0] CMD_WR_CFG = 8'hA1,  // Arbitrary default
  parameter logic [7:0] CMD_RD_CFG = 8'hA2,  // Arbitrary default
  parameter logic [7:0] CMD_WR_HTR = 8'hB1,  // Arbitrary default
  parameter logic [7:0] CMD_RD_HTR = 8'hB2   // Arbitrary default
) (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Serial pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // Supply monitor
  input  wire logic       supply_low_i,
  // Configuration outputs
  output logic [1:0]      conversion_resolution_sel_o,
  output logic            heater_on_o,
  output logic [3:0]      heater_level_o
);

  // ==========================================================================
  // Command decoding
  function automatic logic is_write_cmd(input logic [7:0] code);
    is_write_cmd = (code == CMD_WR_CFG) || (code == CMD_WR_HTR);
  endfunction

  function automatic logic is_known_cmd(input logic [7:0] code);
    is_known_cmd = is_write_cmd(code) || (code == CMD_RD_CFG) || (code == CMD_RD_HTR);
  endfunction

  // ==========================================================================
  // Pin synchronisers
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] supply_sync;
  logic       scl_prev;
  logic       sda_prev;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_sync    <= 2'h3;
      sda_sync    <= 2'h3;
      supply_sync <= 2'h0;
      scl_prev    <= 1'b1;
      sda_prev    <= 1'b1;
    end
    else
    begin
      scl_sync    <= {scl_sync[0], scl_i};
      sda_sync    <= {sda_sync[0], sda_i};
      supply_sync <= {supply_sync[0], supply_low_i};
      scl_prev    <= scl_sync[1];
      sda_prev    <= sda_sync[1];
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_rise  = scl_sync[1] & ~scl_prev;
  assign scl_fall  = ~scl_sync[1] & scl_prev;
  // [R9] Start and stop are SDA edges while SCL stays high
  assign bus_start = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
  assign bus_stop  = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];

  // ==========================================================================
  // Register storage
  logic       res_high;
  logic       res_low;
  logic       heater_on;
  logic [7:0] heater_reg;
  logic       next_res_high;
  logic       next_res_low;
  logic       next_heater_on;
  logic [7:0] next_heater_reg;
  logic [7:0] cfg_value;
  logic       do_write;
  logic       reg_sel;

  // Reserved bits are not stored, so no write can reach them  [R2] [R4]
  assign cfg_value = CFG_RESERVED_BITS_MASK
                   | ({7'h00, res_high}    << CFG_RES_HIGH_BIT)
                   | ({7'h00, supply_sync[1]} << CFG_SUPPLY_BIT)  // [R6]
                   | ({7'h00, heater_on}   << CFG_HEATER_BIT)
                   | ({7'h00, res_low}     << CFG_RES_LOW_BIT);

  // ==========================================================================
  // Serial state machine
  scrb_state_type state;
  scrb_state_type next_state;
  logic [3:0]     bit_cnt;
  logic [3:0]     next_bit_cnt;
  logic [7:0]     shreg;
  logic [7:0]     next_shreg;
  logic           rw_bit;
  logic           next_rw_bit;
  logic           next_reg_sel;
  logic           wr_pending;
  logic           next_wr_pending;
  logic           sda_drive;
  logic           next_sda_drive;

  assign do_write = scl_fall && (state == ST_WDATA) && (bit_cnt == BYTE_BITS);

  always_comb
  begin
    next_state      = state;
    next_bit_cnt    = bit_cnt;
    next_shreg      = shreg;
    next_rw_bit     = rw_bit;
    next_reg_sel    = reg_sel;
    next_wr_pending = wr_pending;
    if (bus_start)
    begin
      next_state   = ST_ADDR;
      next_bit_cnt = 4'h0;
    end
    else if (bus_stop)
    begin
      next_state = ST_IDLE;
    end
    else if (scl_rise)
    begin
      if ((state == ST_ADDR || state == ST_CMD || state == ST_WDATA) && bit_cnt != BYTE_BITS)
      begin
        next_shreg   = {shreg[6:0], sda_sync[1]};
        next_bit_cnt = bit_cnt + 4'h1;
      end
    end
    else if (scl_fall)
    begin
      case (state)
        ST_ADDR:
          if (bit_cnt == BYTE_BITS)
          begin
            // A foreign address is left unanswered
            next_state  = (shreg[7:1] == DEV_ADDR) ? ST_ADDR_ACK : ST_IDLE;
            next_rw_bit = shreg[0];
          end
        ST_ADDR_ACK:
          begin
            next_bit_cnt = 4'h0;
            if (rw_bit)
            begin
              // [R10] One byte from the register the last accepted command, read or write, chose
              next_state = ST_RDATA;
              next_shreg = reg_sel ? heater_reg : cfg_value;
            end
            else
            begin
              next_state = ST_CMD;
            end
          end
        ST_CMD:
          if (bit_cnt == BYTE_BITS)
          begin
            if (is_known_cmd(shreg))  // [R11]
            begin
              next_state      = ST_CMD_ACK;
              next_wr_pending = is_write_cmd(shreg);
              next_reg_sel    = (shreg == CMD_WR_HTR) || (shreg == CMD_RD_HTR);
            end
            else
            begin
              next_state = ST_IDLE;
            end
          end
        ST_CMD_ACK:
          begin
            // A read command waits for the repeated start in idle
            next_state   = wr_pending ? ST_WDATA : ST_IDLE;
            next_bit_cnt = 4'h0;
          end
        ST_WDATA:
          if (bit_cnt == BYTE_BITS)
          begin
            next_state = ST_WDATA_ACK;  // [R9]
          end
        ST_RDATA:
          if (bit_cnt == LAST_TX_BIT)
          begin
            next_state = ST_MACK;
          end
          else
          begin
            next_shreg   = {shreg[6:0], 1'b1};
            next_bit_cnt = bit_cnt + 4'h1;
          end
        ST_WDATA_ACK,
        ST_MACK:
          next_state = ST_IDLE;  // [R10] No checksum byte follows
        default:
          next_state = state;
      endcase
    end
    next_sda_drive = (next_state == ST_ADDR_ACK) || (next_state == ST_CMD_ACK)
                   || (next_state == ST_WDATA_ACK)
                   || ((next_state == ST_RDATA) && !next_shreg[7]);
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state      <= ST_IDLE;
      bit_cnt    <= 4'h0;
      shreg      <= 8'h00;
      rw_bit     <= 1'b0;
      reg_sel    <= 1'b0;
      wr_pending <= 1'b0;
      sda_drive  <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      bit_cnt    <= next_bit_cnt;
      shreg      <= next_shreg;
      rw_bit     <= next_rw_bit;
      reg_sel    <= next_reg_sel;
      wr_pending <= next_wr_pending;
      sda_drive  <= next_sda_drive;
    end
  end

  // ==========================================================================
  // Register update
  always_comb
  begin
    next_res_high   = res_high;
    next_res_low    = res_low;
    next_heater_on  = heater_on;
    next_heater_reg = heater_reg;
    if (do_write && !reg_sel)
    begin
      next_res_high  = shreg[CFG_RES_HIGH_BIT];  // [R5]
      next_res_low   = shreg[CFG_RES_LOW_BIT];
      next_heater_on = shreg[CFG_HEATER_BIT];    // [R7]
    end
    else if (do_write && reg_sel)
    begin
      next_heater_reg = shreg;                    // [R8]
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      res_high   <= CFG_RESET[CFG_RES_HIGH_BIT];
      res_low    <= CFG_RESET[CFG_RES_LOW_BIT];
      heater_on  <= CFG_RESET[CFG_HEATER_BIT];
      heater_reg <= HTR_RESET;
    end
    else
    begin
      res_high   <= next_res_high;
      res_low    <= next_res_low;
      heater_on  <= next_heater_on;
      heater_reg <= next_heater_reg;
    end
  end

  // Open drain: the line is only ever pulled low
  assign sda_o                       = 1'b0;
  assign sda_oe_o                    = sda_drive;
  assign conversion_resolution_sel_o = {res_high, res_low};
  assign heater_on_o                 = heater_on;
  assign heater_level_o              = heater_reg[HTR_LEVEL_MSB:0];

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  chk_reserved_bits_read_ones: assert property ( // [R2]
    scl_fall && state == ST_ADDR_ACK && rw_bit && !reg_sel && !bus_start && !bus_stop
    |=> shreg[5:3] == 3'h7 && shreg[1])
    else $error("reserved bits not read as one");

  chk_res_write: assert property ( // [R5]
    do_write && !reg_sel |=> conversion_resolution_sel_o == {$past(shreg[7]), $past(shreg[0])})
    else $error("resolution selector not taken from bits 7 and 0");

  chk_supply_flag: assert property ( // [R6]
    supply_low_i [*3] |-> cfg_value[CFG_SUPPLY_BIT])
    else $error("supply flag not following monitor");

  chk_flag_readonly: assert property ( // [R4]
    !supply_sync[1] && do_write && !reg_sel |=> !cfg_value[CFG_SUPPLY_BIT])
    else $error("supply flag changed by a write");

  chk_heater_enable: assert property ( // [R7]
    do_write && !reg_sel |=> heater_on_o == $past(shreg[2]))
    else $error("heater enable not written");

  chk_heater_level: assert property ( // [R8]
    do_write && reg_sel |=> heater_level_o == $past(shreg[3:0]) && $stable(res_high))
    else $error("heater level not written");

  chk_addr_ack: assert property ( // [R9]
    scl_fall && state == ST_ADDR && bit_cnt == BYTE_BITS && shreg[7:1] != DEV_ADDR
    && !bus_start && !bus_stop |=> !sda_oe_o [*2])
    else $error("foreign address acknowledged");

  chk_one_byte_read: assert property ( // [R10]
    state == ST_MACK |-> !sda_oe_o)
    else $error("line driven during host acknowledge");

  chk_unknown_cmd: assert property ( // [R11]
    scl_fall && state == ST_CMD && bit_cnt == BYTE_BITS && !is_known_cmd(shreg)
    && !bus_start && !bus_stop |=> state == ST_IDLE && !sda_oe_o)
    else $error("unknown command acknowledged");

endmodule // scrb_register_bank

`default_nettype wire

// ---- bench/scrb_i2c_host.sv ----
`timescale 1ns/100ps
`default_nettype none
// ====================
// Host model: SDA released as 1, line level resolved in the bench
module scrb_i2c_host (
  // Clock and bus
  input  wire logic core_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Quarter bit; pins move only at falling edges
  task automatic qt();
    repeat (5) @(negedge core_clk_i);
  endtask
  // SDA never moves together with SCL, so no false start or stop
  task automatic bit_io(input logic b, output logic r);
    qt();
    sda_o = b;
    qt();
    scl_o = 1'b1;
    qt();
    qt();
    r = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic go(input logic rep);
    if (rep)
    begin
      qt();
      sda_o = 1'b1;
      qt();
      scl_o = 1'b1;
      qt();
    end
    sda_o = 1'b0;
    qt();
    qt();
    scl_o = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
                      output logic ak);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ai, ak);
  endtask
  task automatic halt();
    qt();
    sda_o = 1'b0;
    qt();
    scl_o = 1'b1;
    qt();
    sda_o = 1'b1;
    qt();
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                    output logic [2:0] nk);
    logic [7:0] q;
    go(1'b0);
    xfer({a, 1'b0}, 1'b1, q, nk[2]);
    xfer(c, 1'b1, q, nk[1]);
    xfer(d, 1'b1, q, nk[0]);
    halt();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [7:0] d,
                    output logic [2:0] nk);
    logic [7:0] q;
    logic       x;
    go(1'b0);
    xfer({a, 1'b0}, 1'b1, q, nk[2]);
    xfer(c, 1'b1, q, nk[1]);
    go(1'b1);
    xfer({a, 1'b1}, 1'b1, q, nk[0]);
    xfer(8'hFF, 1'b1, d, x);
    halt();
  endtask
endmodule // scrb_i2c_host
`default_nettype wire

// ---- bench/scrb_register_bank_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module scrb_register_bank_tb;
  import scrb_pkg::*;
  localparam logic [6:0] ADR = 7'h2A;
  localparam logic [7:0] WC = 8'hA1, RC = 8'hA2, WH = 8'hB1, RH = 8'hB2;
  logic       core_clk_i, rst_i, scl, host_sda, sup, sda_o, sda_oe, heat;
  logic [1:0] res;
  logic [3:0] lvl;
  logic [7:0] cfg_m, htr_m, q, d;
  logic [2:0] nk;
  wire        sda_line;
  int         miscompares, samples_checked;
  assign sda_line = host_sda & ~sda_oe;
  scrb_register_bank #(.DEV_ADDR(ADR), .CMD_WR_CFG(WC), .CMD_RD_CFG(RC),
    .CMD_WR_HTR(WH), .CMD_RD_HTR(RH)) u_dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .supply_low_i(sup),
    .conversion_resolution_sel_o(res), .heater_on_o(heat), .heater_level_o(lvl));
  scrb_i2c_host u_host (
    .core_clk_i(core_clk_i), .sda_i(sda_line), .scl_o(scl), .sda_o(host_sda));
  initial
  begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checked %0d, mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ====================
  // Reads both registers back and compares every output with the model
  task automatic check_all();
    u_host.rd(ADR, RC, q, nk);
    chk("cfg ack", 8'h00, {5'h00, nk});
    chk("cfg", {cfg_m[7], sup, 3'b111, cfg_m[2], 1'b1, cfg_m[0]}, q);
    u_host.rd(ADR, RH, q, nk);
    chk("htr", htr_m, q);
    chk("sda value", 8'h00, {7'h00, sda_o});
    chk("res", {6'h00, cfg_m[7], cfg_m[0]}, {6'h00, res});
    chk("heat", {7'h00, cfg_m[2]}, {7'h00, heat});
    chk("lvl", {4'h0, htr_m[3:0]}, {4'h0, lvl});
  endtask
  initial
  begin
    repeat (90000) @(posedge core_clk_i);
    miscompares++;
    end_of_test();
  end
  initial
  begin
    rst_i = 1'b1;
    sup = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    cfg_m = CFG_RESET;
    htr_m = HTR_RESET;
    void'($urandom(64816));
    repeat (6) @(negedge core_clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    check_all();
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      {sup, d} = 9'($urandom);
      // Even passes write reserved bits back as read, odd passes try to clear them
      d = (i % 2 == 0) ? (d | CFG_RESERVED_BITS_MASK) : (d & ~CFG_RESERVED_BITS_MASK);
      u_host.wr(ADR, WC, d, nk);
      chk("wr ack", 8'h00, {5'h00, nk});
      cfg_m = d;
      check_all();
    end
    $display("test config done");
    for (int i = 0; i < 4; i++)
    begin
      d = (i == 0) ? 8'h0F : (i == 1) ? 8'h00 : 8'($urandom);
      u_host.wr(ADR, WH, d, nk);
      chk("wr ack", 8'h00, {5'h00, nk});
      htr_m = d;
      check_all();
    end
    $display("test heater done");
    u_host.wr(ADR ^ 7'h01, WC, 8'hFF, nk);
    chk("bad addr", 8'h07, {5'h00, nk});
    u_host.wr(ADR, 8'hC3, 8'hFF, nk);
    chk("bad cmd", 8'h03, {5'h00, nk});
    check_all();
    $display("test refusal done");
    @(negedge core_clk_i);
    rst_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    rst_i = 1'b0;
    cfg_m = CFG_RESET;
    htr_m = HTR_RESET;
    repeat (4) @(negedge core_clk_i);
    check_all();
    $display("test second reset done");
    end_of_test();
  end
endmodule // scrb_register_bank_tb
`default_nettype wire
